//--- bench/clock_reset_control_asserts.sv
`timescale 1ns/100ps
module clock_reset_control_asserts (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire clock_reset_pkg::clk_cfg_t clk_cfg,
  input wire logic device_reset,
  input wire logic serial_idle,
  input wire logic spi_mode,
  input wire logic ram_access_en,
  input wire logic osc_restart,
  input wire logic energy_pulse_block
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic wr_ok;
  assign wr_ok = reg_wr && !device_reset;
  sequence key_write;
    wr_ok && reg_addr == 7'h6c && reg_wdata == clock_reset_pkg::SOFT_RESET_KEY;
  endsequence
  sequence restart_then_hold;
    osc_restart ##1 device_reset;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_soft_key_starts: assert property (key_write |=> restart_then_hold)
    else $error("key write ignored");
  chk_wrong_key_none: assert property (wr_ok && reg_addr == 7'h6c &&
    reg_wdata != clock_reset_pkg::SOFT_RESET_KEY |=> !osc_restart)
    else $error("wrong key acted");
  chk_idle_tracks_reset: assert property (serial_idle == device_reset)
    else $error("idle differs");
  chk_ram_blocked: assert property (device_reset |-> !ram_access_en)
    else $error("ram open");
  chk_restart_uart: assert property ($rose(osc_restart) |-> !spi_mode)
    else $error("spi kept");
  chk_mode_nine: assert property (wr_ok && reg_addr == 7'h02 && reg_wdata[7:4] == 4'h9
    |-> ##2 clk_cfg.points == 8'h10 && clk_cfg.sys_div == 5'h10)
    else $error("mode nine wrong");
  chk_adc_quarter: assert property (wr_ok && reg_addr == 7'h01 && reg_wdata[31:30] == 2'h2
    |-> ##2 clk_cfg.adc_div == 6'h20)
    else $error("adc quarter wrong");
  chk_ext_powerdown: assert property (wr_ok && reg_addr == 7'h01 && reg_wdata[23]
    |-> ##2 !clk_cfg.ext_enable)
    else $error("ext input on");
  chk_energy_settle: assert property (wr_ok && reg_addr == 7'h03 &&
    reg_wdata[23] != clk_cfg.energy_slow |-> ##[1:3] energy_pulse_block)
    else $error("no pulse block");
  chk_key_unreadable: assert property (reg_rd && reg_addr == 7'h6c |=> reg_rdata == 32'h0)
    else $error("key readable");
endmodule
bind clock_reset_control clock_reset_control_asserts chk (.*);

//--- bench/host_model.sv
`timescale 1ns/100ps
module host_model #(
  parameter int MIN_LOW = 20
) (
  input wire logic clock,
  input wire logic pin_cmd,
  input wire logic line_cmd,
  output logic reset_pin_n,
  output logic rx_line,
  output logic addr_hi_or_chip_select,
  output logic addr_lo_or_serial_clock
);
  int held = 0;
  // Address pins rest at their pull-up level; the SPI line reset is not driven.
  assign addr_hi_or_chip_select = 1'b1;
  assign addr_lo_or_serial_clock = 1'b1;
  always @(posedge clock) held <= (pin_cmd || (held != 0 && held < MIN_LOW)) ? held + 1 : 0;
  assign reset_pin_n = !(pin_cmd || (held != 0 && held < MIN_LOW));
  assign rx_line = !line_cmd;
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
module tb;
  logic clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, spi_init_done = 0;
  logic ram_check_fail = 0, ext_fast_clk_in = 0, ext_run = 1, pin_cmd = 0, line_cmd = 0;
  logic [6:0] reg_addr = 7'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reset_pin_n, rx_line, addr_hi_or_chip_select, addr_lo_or_serial_clock;
  logic device_reset, serial_idle, spi_mode, ram_access_en, osc_restart, energy_pulse_block;
  logic [12:0] got;
  clock_reset_pkg::clk_cfg_t clk_cfg;
  int err_count = 0, tests_run = 0, cycles = 0, n;
  typedef struct packed {logic [6:0] a; logic [31:0] d; logic [12:0] e;} row_t;
  row_t rows [17] = '{'{2, 0, 'h1001}, '{2, 'h10, 'h801}, '{2, 'h20, 'h401}, '{2, 'h30, 'h1001},
    '{2, 'h60, 'h802}, '{2, 'h70, 'h402}, '{2, 'h80, 'h408}, '{2, 'h90, 'h210}, '{2, 'hf0, 'h1001},
    '{1, 0, 'h1220}, '{1, 'h5f00_0000, 'h113f}, '{1, 'ha100_0000, 'h1801},
    '{1, 'hc000_0000, 'h1420}, '{1, 'h80_0000, 'h220}, '{1, 'h80, 'h220}, '{1, 0, 'h1220},
    '{'h6c, 0, 'h1220}};
  clock_reset_control #(.SOFT_EXIT_CYCLES(26), .PIN_EXIT_CYCLES(36), .PIN_LOW_CYCLES(20),
    .LINE_LOW_CYCLES(40), .RAM_CHECK_CYCLES(50)) uut (.*);
  host_model host (.*);
  always #12.5 clock = ~clock;
  // Twice the full power-on exit, leaving as many cycles again for the pin resets.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (ext_run && cycles % 3 == 0) ext_fast_clk_in <= #1 ~ext_fast_clk_in;
    if (cycles == 40000) begin
      err_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [31:0] exp, seen);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wr(logic [6:0] a, logic [31:0] d);
    step(1);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 0;
  endtask
  task automatic rd(logic [6:0] a);
    step(1);
    reg_rd = 1;
    reg_addr = a;
    step(1);
    reg_rd = 0;
  endtask
  task automatic wait_rst(logic lvl);
    n = 0;
    while (device_reset !== lvl && n < 25000) begin
      step(1);
      n++;
    end
    check("device_reset", lvl, device_reset);
  endtask
  task automatic cause(logic [2:0] c);
    rd(7'h74);
    check("cause", c, reg_rdata[22:20]);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    step(5);
    sys_rst = 0;
    check("in reset", 1, device_reset);
    wait_rst(0);
    check("por exit", 1, n <= clock_reset_pkg::POR_EXIT_CYCLES + 2);
    step(52);
    check("ram open", 1, ram_access_en);
    cause(1);
    check("ext used", 0, reg_rdata[2]);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      step(2);
      got = rows[i].a == 7'h02 ? {clk_cfg.points, clk_cfg.sys_div} : {clk_cfg.ext_enable,
        clk_cfg.adc_div, clk_cfg.trim_up, clk_cfg.trim_steps};
      check("cfg", rows[i].e, got);
      rd(rows[i].a);
      check("readback", rows[i].d, reg_rdata);
    end
    ext_run = 0;
    step(80);
    check("rc used", 1, clk_cfg.use_rc);
    ext_run = 1;
    wr(7'h6c, 32'h4572_beae);
    step(3);
    check("no reset", 0, device_reset);
    cause(1);
    wr(7'h03, 32'h80_0000);
    step(2);
    check("energy block", 1, energy_pulse_block);
    step(30);
    spi_init_done = 1;
    step(1);
    spi_init_done = 0;
    step(2);
    check("spi on", 1, spi_mode);
    wr(7'h6c, clock_reset_pkg::SOFT_RESET_KEY);
    wait_rst(1);
    check("uart back", 0, spi_mode);
    wait_rst(0);
    check("soft exit", 1, n <= 28);
    cause(4);
    step(60);
    pin_cmd = 1;
    wait_rst(1);
    pin_cmd = 0;
    wait_rst(0);
    check("pin exit", 1, n >= 36);
    cause(2);
    ram_check_fail = 1;
    line_cmd = 1;
    wait_rst(1);
    line_cmd = 0;
    wait_rst(0);
    cause(3);
    step(60);
    check("ram shut", 0, ram_access_en);
    stop_test();
  end
endmodule

//--- rtl/clock_reset_control.sv
// Functional notes
// (RULE1) Divide the 6.5536 MHz external clock for the system per operating mode.
// (RULE2) ADC clock select scales the 819.2 kHz base by x1, x2, x1/4, x1/2.
// (RULE3) With no external clock present, run everything from the internal RC clock.
// (RULE4) Software keeps the RC power-down bit at zero.
// (RULE5) External clock power-down bit set to one disables the external input.
// (RULE6) Trim codes 0-31 raise, 32-63 lower RC frequency in 1.25% steps.
// (RULE7) Mode picks points and clock; 3-5 reserved; unknown modes act as mode 0.
// (RULE8) Energy clock select: 204.8 kHz or 32768 Hz; pulses blocked 107 us after switch.
// (RULE9) A free-running 32 kHz slow tick filters reset, receive and address pins.
// (RULE10) Every reset restarts the fast oscillator and reference.
// (RULE11) Reset cause reads 001 POR, 010 pin, 011 receive line, 100 software.
// (RULE12) Writing the key to the software reset register resets the device.
// (RULE13) Software reset finishes within 650 us.
// (RULE14) Power-on reset finishes within 500 us after release.
// (RULE15) Pin low 2 ms resets; exit 900 us after pin returns high.
// (RULE16) UART mode: receive line low 92.5 ms resets; exit 900 us after release.
// (RULE17) SPI mode: data-in and select low 92.5 ms with serial clock above 50 Hz.
// (RULE18) No RAM access in reset; 1.25 ms self-check gates access on exit.
// (RULE19) Serial interface idles in reset and runs as soon as reset ends.
// (RULE20) After every reset the serial interface is UART until SPI is initialised.
// (RULE21) Any other value written to the software reset register does nothing.
// (RULE22) Reset cause holds until the next recognised reset.
`timescale 1ns/100ps
module clock_reset_control #(
  parameter int POR_EXIT_CYCLES = clock_reset_pkg::POR_EXIT_CYCLES,
  parameter int SOFT_EXIT_CYCLES = clock_reset_pkg::SOFT_EXIT_CYCLES,
  parameter int PIN_EXIT_CYCLES = clock_reset_pkg::PIN_EXIT_CYCLES,
  parameter int PIN_LOW_CYCLES = clock_reset_pkg::PIN_LOW_CYCLES,
  parameter int LINE_LOW_CYCLES = clock_reset_pkg::LINE_LOW_CYCLES,
  parameter int RAM_CHECK_CYCLES = clock_reset_pkg::RAM_CHECK_CYCLES,
  parameter int ENERGY_SETTLE_CYCLES = clock_reset_pkg::ENERGY_SETTLE_CYCLES,
  parameter int SCK_QUIET_CYCLES = clock_reset_pkg::SCK_QUIET_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic rx_line,
  input wire logic addr_hi_or_chip_select,
  input wire logic addr_lo_or_serial_clock,
  input wire logic ext_fast_clk_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic spi_init_done,
  input wire logic ram_check_fail,
  output logic [31:0] reg_rdata,
  output clock_reset_pkg::clk_cfg_t clk_cfg,
  output logic device_reset,
  output logic serial_idle,
  output logic spi_mode,
  output logic ram_access_en,
  output logic osc_restart,
  output logic energy_pulse_block
);

  ////////////////////////////////////////////////////////////////////////////////
  // Slow tick and pin filtering.

  logic [10:0] slow_cnt_reg;
  logic slow_tick_reg;
  logic [3:0] pin_f;
  logic ext_f;
  logic sck_prev_reg;
  logic ext_prev_reg;
  logic sck_edge;
  logic ext_edge;

  // (RULE9) Free-running filter tick.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slow_cnt_reg <= '0;
      slow_tick_reg <= 1'b0;
    end else if (slow_cnt_reg == 11'(clock_reset_pkg::SLOW_TICK_CYCLES - 1)) begin
      slow_cnt_reg <= '0;
      slow_tick_reg <= 1'b1;
    end else begin
      slow_cnt_reg <= slow_cnt_reg + 1'b1;
      slow_tick_reg <= 1'b0;
    end
  end

  // (RULE9) Filtered reset, receive and address pins.
  pin_filter #(.WIDTH(4), .TICKED(1'b1)) u_pin_filter (
    .clock(clock),
    .sys_rst(sys_rst),
    .slow_tick(slow_tick_reg),
    .pins({reset_pin_n, rx_line, addr_hi_or_chip_select, addr_lo_or_serial_clock}),
    .filt(pin_f)
  );

  pin_filter #(.WIDTH(1), .TICKED(1'b0)) u_ext_filter (
    .clock(clock),
    .sys_rst(sys_rst),
    .slow_tick(1'b0),
    .pins(ext_fast_clk_in),
    .filt(ext_f)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sck_prev_reg <= 1'b1;
      ext_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= pin_f[0];
      ext_prev_reg <= ext_f;
    end
  end

  assign sck_edge = pin_f[0] != sck_prev_reg;
  assign ext_edge = ext_f != ext_prev_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Hold detectors.

  logic pin_hold;
  logic uart_hold;
  logic spi_hold;
  logic sck_quiet;
  logic ext_missing;

  // (RULE15) Reset pin held low.
  hold_timer #(.LIMIT(PIN_LOW_CYCLES)) u_pin_hold (
    .clock(clock),
    .sys_rst(sys_rst),
    .active(!pin_f[3]),
    .reached(pin_hold)
  );

  // (RULE16) Receive line held low in UART mode.
  hold_timer #(.LIMIT(LINE_LOW_CYCLES)) u_uart_hold (
    .clock(clock),
    .sys_rst(sys_rst),
    .active(!pin_f[2] && !spi_mode),
    .reached(uart_hold)
  );

  // (RULE17) Data-in and select low while the serial clock keeps running.
  hold_timer #(.LIMIT(LINE_LOW_CYCLES)) u_spi_hold (
    .clock(clock),
    .sys_rst(sys_rst),
    .active(!pin_f[2] && !pin_f[1] && spi_mode && !sck_quiet),
    .reached(spi_hold)
  );

  hold_timer #(.LIMIT(SCK_QUIET_CYCLES)) u_sck_quiet (
    .clock(clock),
    .sys_rst(sys_rst),
    .active(!sck_edge),
    .reached(sck_quiet)
  );

  // (RULE3) External clock absence watchdog.
  hold_timer #(.LIMIT(clock_reset_pkg::EXT_MISS_CYCLES)) u_ext_miss (
    .clock(clock),
    .sys_rst(sys_rst),
    .active(!ext_edge),
    .reached(ext_missing)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Reset sequencing.

  clock_reset_pkg::reset_state_t state_reg;
  logic [31:0] seq_cnt_reg;
  logic [31:0] exit_limit;
  logic [2:0] cause_reg;
  logic serial_active;
  logic in_reset;
  logic event_pin;
  logic event_line;
  logic event_soft;
  logic event_any;

  assign serial_active = state_reg == clock_reset_pkg::ST_RUN
      || state_reg == clock_reset_pkg::ST_RAMCHK;
  assign in_reset = !serial_active;
  assign event_pin = state_reg != clock_reset_pkg::ST_HOLD && pin_hold;
  assign event_line = state_reg != clock_reset_pkg::ST_HOLD && !pin_hold
      && (uart_hold || spi_hold);
  // (RULE12) Key compare; (RULE21) any other value is ignored.
  assign event_soft = serial_active && !pin_hold && !uart_hold && !spi_hold && reg_wr
      && reg_addr == clock_reset_pkg::SOFTWARE_RESET_KEY_IDX
      && reg_wdata == clock_reset_pkg::SOFT_RESET_KEY;
  assign event_any = event_pin || event_line || event_soft;

  // (RULE13) (RULE14) (RULE15) Exit delay chosen by cause.
  always_comb begin
    if (cause_reg == clock_reset_pkg::CAUSE_POR) begin
      exit_limit = 32'(POR_EXIT_CYCLES);
    end else if (cause_reg == clock_reset_pkg::CAUSE_SOFT) begin
      exit_limit = 32'(SOFT_EXIT_CYCLES);
    end else begin
      exit_limit = 32'(PIN_EXIT_CYCLES);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= clock_reset_pkg::ST_EXIT;
      seq_cnt_reg <= '0;
    end else if (event_pin || event_line) begin
      state_reg <= clock_reset_pkg::ST_HOLD;
      seq_cnt_reg <= '0;
    end else if (event_soft) begin
      state_reg <= clock_reset_pkg::ST_EXIT;
      seq_cnt_reg <= '0;
    end else begin
      case (state_reg)
        // (RULE16) Leave the hold once the pin and line are both high.
        clock_reset_pkg::ST_HOLD: begin
          if (pin_f[3] && pin_f[2]) begin
            state_reg <= clock_reset_pkg::ST_EXIT;
          end
          seq_cnt_reg <= '0;
        end
        clock_reset_pkg::ST_EXIT: begin
          if (seq_cnt_reg >= exit_limit - 32'h1) begin
            state_reg <= clock_reset_pkg::ST_RAMCHK;
            seq_cnt_reg <= '0;
          end else begin
            seq_cnt_reg <= seq_cnt_reg + 32'h1;
          end
        end
        // (RULE18) Self-check window.
        clock_reset_pkg::ST_RAMCHK: begin
          if (seq_cnt_reg >= 32'(RAM_CHECK_CYCLES - 1)) begin
            state_reg <= clock_reset_pkg::ST_RUN;
            seq_cnt_reg <= '0;
          end else begin
            seq_cnt_reg <= seq_cnt_reg + 32'h1;
          end
        end
        default: begin
          seq_cnt_reg <= '0;
        end
      endcase
    end
  end

  // (RULE11) (RULE22) Cause is loaded only by a recognised reset.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cause_reg <= clock_reset_pkg::CAUSE_POR;
    end else if (event_pin) begin
      cause_reg <= clock_reset_pkg::CAUSE_PIN;
    end else if (event_line) begin
      cause_reg <= clock_reset_pkg::CAUSE_LINE;
    end else if (event_soft) begin
      cause_reg <= clock_reset_pkg::CAUSE_SOFT;
    end
  end

  // (RULE10) Restart pulse for the fast oscillator and reference.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      osc_restart <= 1'b1;
    end else begin
      osc_restart <= event_any;
    end
  end

  // (RULE19) Serial interface idle during reset.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      device_reset <= 1'b1;
      serial_idle <= 1'b1;
    end else begin
      device_reset <= in_reset;
      serial_idle <= in_reset;
    end
  end

  // (RULE18) Access granted only after a clean self-check.
  always_ff @(posedge clock) begin
    if (sys_rst || in_reset || event_any) begin
      ram_access_en <= 1'b0;
    end else if (state_reg == clock_reset_pkg::ST_RAMCHK
        && seq_cnt_reg >= 32'(RAM_CHECK_CYCLES - 1)) begin
      ram_access_en <= !ram_check_fail;
    end
  end

  // (RULE20) UART after every reset until SPI is initialised.
  always_ff @(posedge clock) begin
    if (sys_rst || in_reset || event_any) begin
      spi_mode <= 1'b0;
    end else if (spi_init_done) begin
      spi_mode <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers. Writes are dropped while the serial interface is idle.

  logic [31:0] analog_control_one_reg;
  logic [31:0] metering_control_zero_reg;
  logic [31:0] metering_control_one_reg;
  logic wr_ok;

  assign wr_ok = reg_wr && serial_active && !event_any;

  always_ff @(posedge clock) begin
    if (sys_rst || in_reset || event_any) begin
      analog_control_one_reg <= clock_reset_pkg::CONTROL_RESET_VALUE;
      metering_control_zero_reg <= clock_reset_pkg::CONTROL_RESET_VALUE;
      metering_control_one_reg <= clock_reset_pkg::CONTROL_RESET_VALUE;
    end else if (wr_ok) begin
      if (reg_addr == clock_reset_pkg::ANALOG_CONTROL_ONE_IDX) begin
        analog_control_one_reg <= reg_wdata;
      end else if (reg_addr == clock_reset_pkg::METERING_CONTROL_ZERO_IDX) begin
        metering_control_zero_reg <= reg_wdata;
      end else if (reg_addr == clock_reset_pkg::METERING_CONTROL_ONE_IDX) begin
        metering_control_one_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == clock_reset_pkg::ANALOG_CONTROL_ONE_IDX) begin
        reg_rdata <= analog_control_one_reg;
      end else if (reg_addr == clock_reset_pkg::METERING_CONTROL_ZERO_IDX) begin
        reg_rdata <= metering_control_zero_reg;
      end else if (reg_addr == clock_reset_pkg::METERING_CONTROL_ONE_IDX) begin
        reg_rdata <= metering_control_one_reg;
      end else if (reg_addr == clock_reset_pkg::SYSTEM_STATUS_IDX) begin
        reg_rdata <= '0;
        reg_rdata[clock_reset_pkg::CAUSE_LSB +: 3] <= cause_reg;
        reg_rdata[clock_reset_pkg::STS_RAM_OK_BIT] <= ram_access_en;
        reg_rdata[clock_reset_pkg::STS_SPI_BIT] <= spi_mode;
        reg_rdata[clock_reset_pkg::STS_RC_BIT] <= clk_cfg.use_rc;
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock configuration.

  logic [3:0] mode;
  logic [1:0] adc_sel;
  logic ext_en;

  assign mode = metering_control_zero_reg[clock_reset_pkg::MODE_LSB +: 4];
  assign adc_sel = analog_control_one_reg[clock_reset_pkg::ADC_SEL_LSB +: 2];
  // (RULE5) Either disable bit turns the external input off.
  assign ext_en = !analog_control_one_reg[clock_reset_pkg::EXT_PD_BIT]
      && !analog_control_one_reg[clock_reset_pkg::EXT_EN_N_BIT];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clk_cfg <= '0;
    end else begin
      clk_cfg.ext_enable <= ext_en;
      // (RULE3) Fall back to the RC clock when the input is absent or off.
      clk_cfg.use_rc <= ext_missing || !ext_en;
      // (RULE4) (RULE10) Forced on through reset whatever software last wrote.
      clk_cfg.rc_enable <= in_reset || !analog_control_one_reg[clock_reset_pkg::RC_PD_BIT];
      // (RULE6) Trim direction and step count.
      clk_cfg.trim_up <= !analog_control_one_reg[clock_reset_pkg::TRIM_DIR_BIT];
      clk_cfg.trim_steps <= analog_control_one_reg[clock_reset_pkg::TRIM_LSB +: 5];
      clk_cfg.energy_slow <= metering_control_one_reg[clock_reset_pkg::ENERGY_SEL_BIT];
      // (RULE2) ADC scale.
      case (adc_sel)
        2'h1: clk_cfg.adc_div <= clock_reset_pkg::ADC_DIV_X2;
        2'h2: clk_cfg.adc_div <= clock_reset_pkg::ADC_DIV_QUARTER;
        2'h3: clk_cfg.adc_div <= clock_reset_pkg::ADC_DIV_HALF;
        default: clk_cfg.adc_div <= clock_reset_pkg::ADC_DIV_X1;
      endcase
      // (RULE1) (RULE7) Mode decode; reserved and unknown codes act as mode 0.
      case (mode)
        4'h1: begin
          clk_cfg.sys_div <= clock_reset_pkg::SYS_DIV_FULL;
          clk_cfg.points <= clock_reset_pkg::POINTS_64;
        end
        4'h2: begin
          clk_cfg.sys_div <= clock_reset_pkg::SYS_DIV_FULL;
          clk_cfg.points <= clock_reset_pkg::POINTS_32;
        end
        4'h6: begin
          clk_cfg.sys_div <= clock_reset_pkg::SYS_DIV_HALF;
          clk_cfg.points <= clock_reset_pkg::POINTS_64;
        end
        4'h7: begin
          clk_cfg.sys_div <= clock_reset_pkg::SYS_DIV_HALF;
          clk_cfg.points <= clock_reset_pkg::POINTS_32;
        end
        4'h8: begin
          clk_cfg.sys_div <= clock_reset_pkg::SYS_DIV_EIGHTH;
          clk_cfg.points <= clock_reset_pkg::POINTS_32;
        end
        4'h9: begin
          clk_cfg.sys_div <= clock_reset_pkg::SYS_DIV_SIXTEENTH;
          clk_cfg.points <= clock_reset_pkg::POINTS_16;
        end
        default: begin
          clk_cfg.sys_div <= clock_reset_pkg::SYS_DIV_FULL;
          clk_cfg.points <= clock_reset_pkg::POINTS_128;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Energy clock switch blanking.

  logic energy_sel_prev_reg;
  logic [31:0] settle_cnt_reg;
  logic energy_switch;

  assign energy_switch = metering_control_one_reg[clock_reset_pkg::ENERGY_SEL_BIT]
      != energy_sel_prev_reg;

  // (RULE8) Pulse output held off while the new accumulator clock settles.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      energy_sel_prev_reg <= 1'b0;
      settle_cnt_reg <= '0;
      energy_pulse_block <= 1'b0;
    end else begin
      energy_sel_prev_reg <= metering_control_one_reg[clock_reset_pkg::ENERGY_SEL_BIT];
      if (energy_switch) begin
        settle_cnt_reg <= 32'(ENERGY_SETTLE_CYCLES);
      end else if (settle_cnt_reg != 32'h0) begin
        settle_cnt_reg <= settle_cnt_reg - 32'h1;
      end
      energy_pulse_block <= energy_switch || settle_cnt_reg > 32'h1;
    end
  end

endmodule

//--- rtl/clock_reset_pkg.sv
package clock_reset_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices on the documented register port.
  localparam logic [6:0] ANALOG_CONTROL_ONE_IDX = 7'h01;
  localparam logic [6:0] METERING_CONTROL_ZERO_IDX = 7'h02;
  localparam logic [6:0] METERING_CONTROL_ONE_IDX = 7'h03;
  localparam logic [6:0] SOFTWARE_RESET_KEY_IDX = 7'h6c;
  localparam logic [6:0] SYSTEM_STATUS_IDX = 7'h74;

  localparam logic [31:0] CONTROL_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] SOFT_RESET_KEY = 32'h4572_beaf;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int ADC_SEL_LSB = 30;
  localparam int TRIM_LSB = 24;
  localparam int TRIM_DIR_BIT = 29;
  localparam int EXT_PD_BIT = 23;
  localparam int RC_PD_BIT = 22;
  localparam int EXT_EN_N_BIT = 7;
  localparam int MODE_LSB = 4;
  localparam int ENERGY_SEL_BIT = 23;
  localparam int CAUSE_LSB = 20;
  localparam int STS_RAM_OK_BIT = 0;
  localparam int STS_SPI_BIT = 1;
  localparam int STS_RC_BIT = 2;

  localparam logic [2:0] CAUSE_POR = 3'h1;
  localparam logic [2:0] CAUSE_PIN = 3'h2;
  localparam logic [2:0] CAUSE_LINE = 3'h3;
  localparam logic [2:0] CAUSE_SOFT = 3'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock divider settings, relative to the 6.5536 MHz source.
  localparam logic [4:0] SYS_DIV_FULL = 5'h01;
  localparam logic [4:0] SYS_DIV_HALF = 5'h02;
  localparam logic [4:0] SYS_DIV_EIGHTH = 5'h08;
  localparam logic [4:0] SYS_DIV_SIXTEENTH = 5'h10;
  localparam logic [5:0] ADC_DIV_X1 = 6'h08;
  localparam logic [5:0] ADC_DIV_X2 = 6'h04;
  localparam logic [5:0] ADC_DIV_QUARTER = 6'h20;
  localparam logic [5:0] ADC_DIV_HALF = 6'h10;
  localparam logic [7:0] POINTS_128 = 8'h80;
  localparam logic [7:0] POINTS_64 = 8'h40;
  localparam logic [7:0] POINTS_32 = 8'h20;
  localparam logic [7:0] POINTS_16 = 8'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing, in nanoseconds, and the derived cycle counts.
  localparam int CLK_PERIOD_NS = 25;
  localparam int POR_EXIT_MAX_NS = 500_000;
  localparam int SOFT_EXIT_MAX_NS = 650_000;
  localparam int PIN_EXIT_NS = 900_000;
  localparam int PIN_LOW_MIN_NS = 2_000_000;
  localparam int LINE_LOW_NS = 92_500_000;
  localparam int RAM_CHECK_NS = 1_250_000;
  localparam int ENERGY_SETTLE_NS = 107_000;
  localparam int SCK_MIN_PERIOD_NS = 20_000_000;
  localparam int SLOW_RC_PERIOD_NS = 31_250;
  localparam int POR_EXIT_CYCLES = POR_EXIT_MAX_NS / CLK_PERIOD_NS;
  localparam int SOFT_EXIT_CYCLES = SOFT_EXIT_MAX_NS / CLK_PERIOD_NS;
  localparam int PIN_EXIT_CYCLES = (PIN_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_LOW_CYCLES = (PIN_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINE_LOW_CYCLES = (LINE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAM_CHECK_CYCLES = (RAM_CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ENERGY_SETTLE_CYCLES = (ENERGY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_QUIET_CYCLES = SCK_MIN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLOW_TICK_CYCLES = SLOW_RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int EXT_MISS_CYCLES = 64;

  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_EXIT = 2'b10,
    ST_RAMCHK = 2'b11
  } reset_state_t;

  typedef struct packed {
    logic use_rc;
    logic ext_enable;
    logic rc_enable;
    logic trim_up;
    logic [4:0] trim_steps;
    logic [4:0] sys_div;
    logic [5:0] adc_div;
    logic [7:0] points;
    logic energy_slow;
  } clk_cfg_t;

endpackage

//--- rtl/hold_timer.sv
`timescale 1ns/100ps
module hold_timer #(
  parameter int LIMIT = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic active,
  output logic reached
);

  localparam int W = $clog2(LIMIT + 1);

  logic [W-1:0] count_reg;

  // The count saturates, so a long hold cannot wrap and drop the flag.
  always_ff @(posedge clock) begin
    if (sys_rst || !active) begin
      count_reg <= '0;
    end else if (count_reg != W'(LIMIT)) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reached <= 1'b0;
    end else begin
      reached <= active && (count_reg >= W'(LIMIT - 1));
    end
  end

endmodule

//--- rtl/pin_filter.sv
`timescale 1ns/100ps
module pin_filter #(
  parameter int WIDTH = 1,
  parameter bit TICKED = 1'b1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic slow_tick,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] filt
);

  logic [WIDTH-1:0] sync1_reg;
  logic [WIDTH-1:0] sync2_reg;
  logic [WIDTH-1:0] sync3_reg;
  logic sample;

  // Pins idle high through their pull-ups, so the filter starts high.
  assign sample = TICKED ? slow_tick : 1'b1;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        sync1_reg[i] <= 1'b1;
        sync2_reg[i] <= 1'b1;
        sync3_reg[i] <= 1'b1;
        filt[i] <= 1'b1;
      end else begin
        sync1_reg[i] <= pins[i];
        sync2_reg[i] <= sync1_reg[i];
        sync3_reg[i] <= sync2_reg[i];
        if (sample && sync2_reg[i] == sync3_reg[i]) begin
          filt[i] <= sync3_reg[i];
        end
      end
    end
  end

endmodule
